// ==== design/registered_bus_transceiver.sv ====
// Purpose: Byte-split registered bus transceiver behind AXI4-Lite control
// Assumes: Port levels and capture clocks are synchronous to aclk
// Notes: Capture edges also push both port levels into a capture FIFO
//
// Functional notes
// - Storage registers load from source port only on capture clock rise.
// - Without a rising capture edge the storage register holds.
// - Capture is never gated by gate, flow or select controls.
// - Output gate high isolates both ports; storage kept.
// - In isolation, capture rises still store port levels.
// - Gate low: flow high drives B, flow low drives A.
// - Driving B with B select low shows live A data.
// - Driving B with B select high shows the A storage register.
// - Driving A shows live B, or B storage when A select high.
// - Capture A while driving B; stored selection shows new value.
// - Capture B while driving A; stored selection shows new value.
// - Input-side data may be stored into either or both registers.
// - A half never drives ports A and B together; the two halves may drive opposite ports.
// - Two independent byte halves, each with its own controls.
//
// The AXI4-Lite slave port and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
module registered_bus_transceiver
  import xcvr_pkg::*;
#(
  parameter int unsigned HALF_W = xcvr_pkg::HALF_WIDTH,
  parameter int unsigned DEPTH = xcvr_pkg::FIFO_DEPTH
) (
  input wire logic aclk, // Clock, 40 MHz
  input wire logic aresetn, // Sync reset, active low
  input wire logic ce, // Clock enable, freezes all state
  input wire logic [7:0] s_axi_awaddr, // Write address
  input wire logic s_axi_awvalid, // Write address valid
  output logic s_axi_awready, // Write address ready
  input wire logic [31:0] s_axi_wdata, // Write data
  input wire logic [3:0] s_axi_wstrb, // Write strobes
  input wire logic s_axi_wvalid, // Write data valid
  output logic s_axi_wready, // Write data ready
  output logic [1:0] s_axi_bresp, // Write response
  output logic s_axi_bvalid, // Write response valid
  input wire logic s_axi_bready, // Write response ready
  input wire logic [7:0] s_axi_araddr, // Read address
  input wire logic s_axi_arvalid, // Read address valid
  output logic s_axi_arready, // Read address ready
  output logic [31:0] s_axi_rdata, // Read data
  output logic [1:0] s_axi_rresp, // Read response
  output logic s_axi_rvalid, // Read valid
  input wire logic s_axi_rready, // Read ready
  input wire logic [2*HALF_W-1:0] port_a_in, // Port A level
  output logic [2*HALF_W-1:0] port_a_out, // Port A drive value
  output logic [2*HALF_W-1:0] port_a_oe, // Port A enable, high drives
  input wire logic [2*HALF_W-1:0] port_b_in, // Port B level
  output logic [2*HALF_W-1:0] port_b_out, // Port B drive value
  output logic [2*HALF_W-1:0] port_b_oe, // Port B enable, high drives
  input wire logic [1:0] a_to_b_capture_clock, // Per-half A capture clock
  input wire logic [1:0] b_to_a_capture_clock // Per-half B capture clock
);
  import xcvr_pkg::*;

  localparam int unsigned PW = 2 * HALF_W;

  // ------------------------------------------------------------------
  // Control register and per-half decode
  // ------------------------------------------------------------------
  logic [31:0] ctrl;
  half_ctrl_s half_ctrl [2];

  function automatic half_ctrl_s decode_half(input logic [31:0] c,
                                             input int unsigned h);
    half_ctrl_s r;
    r.output_gate = c[GATE_BIT + CTRL_STRIDE*h];
    r.flow_sense = c[FLOW_BIT + CTRL_STRIDE*h];
    r.b_side_source_select = c[BSEL_BIT + CTRL_STRIDE*h];
    r.a_side_source_select = c[ASEL_BIT + CTRL_STRIDE*h];
    return r;
  endfunction : decode_half

  function automatic logic [31:0] apply_strobes(input logic [31:0] old,
                                                input logic [31:0] data,
                                                input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[8*i +: 8] = data[8*i +: 8];
      end
    end
    return r;
  endfunction : apply_strobes

  function automatic logic is_ctrl_addr(input logic [7:0] a);
    return a[7:2] == CTRL_OFFSET[7:2];
  endfunction : is_ctrl_addr

  assign half_ctrl[0] = decode_half(ctrl, 0);
  assign half_ctrl[1] = decode_half(ctrl, 1);

  // ------------------------------------------------------------------
  // Capture edge detection
  // ------------------------------------------------------------------
  logic [1:0] cab_prev;
  logic [1:0] cba_prev;
  logic [1:0] cab_rise;
  logic [1:0] cba_rise;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      // Ones: a clock already high at release is no edge
      cab_prev <= 2'b11;
      cba_prev <= 2'b11;
    end else if (ce) begin
      cab_prev <= a_to_b_capture_clock;
      cba_prev <= b_to_a_capture_clock;
    end
  end

  assign cab_rise = a_to_b_capture_clock & ~cab_prev;
  assign cba_rise = b_to_a_capture_clock & ~cba_prev;

  // ------------------------------------------------------------------
  // Storage registers, deliberately without reset
  // ------------------------------------------------------------------
  logic [PW-1:0] a_storage_register;
  logic [PW-1:0] b_storage_register;

  always_ff @(posedge aclk) begin
    if (ce) begin
      for (int h = 0; h < 2; h++) begin
        if (cab_rise[h]) begin
          a_storage_register[HALF_W*h +: HALF_W] <=
            port_a_in[HALF_W*h +: HALF_W];
        end
        if (cba_rise[h]) begin
          b_storage_register[HALF_W*h +: HALF_W] <=
            port_b_in[HALF_W*h +: HALF_W];
        end
      end
    end
  end

  // ------------------------------------------------------------------
  // Port drive, per half
  // ------------------------------------------------------------------
  // Independent halves
  always_comb begin
    port_a_out = '0;
    port_a_oe = '0;
    port_b_out = '0;
    port_b_oe = '0;
    for (int h = 0; h < 2; h++) begin
      if (!half_ctrl[h].output_gate && half_ctrl[h].flow_sense) begin
        port_b_oe[HALF_W*h +: HALF_W] = '1;
        port_b_out[HALF_W*h +: HALF_W] = half_ctrl[h].b_side_source_select ?
          a_storage_register[HALF_W*h +: HALF_W] :
          port_a_in[HALF_W*h +: HALF_W];
      end else if (!half_ctrl[h].output_gate) begin
        port_a_oe[HALF_W*h +: HALF_W] = '1;
        port_a_out[HALF_W*h +: HALF_W] = half_ctrl[h].a_side_source_select ?
          b_storage_register[HALF_W*h +: HALF_W] :
          port_b_in[HALF_W*h +: HALF_W];
      end
    end
  end

  // ------------------------------------------------------------------
  // Capture FIFO: port levels at each capture edge, dropped when full
  // ------------------------------------------------------------------
  capture_word_s cap_word;
  capture_word_s head_word;
  logic cap_valid;
  logic cap_ready;
  logic head_valid;
  logic head_pop;
  logic [7:0] overflow_count;

  assign cap_word.a_level = port_a_in;
  assign cap_word.b_level = port_b_in;
  assign cap_valid = |{cab_rise, cba_rise};

  sync_fifo #(
    .WIDTH($bits(capture_word_s)),
    .DEPTH(DEPTH)
  ) u_capture_fifo (
    .aclk(aclk),
    .aresetn(aresetn),
    .ce(ce),
    .in_valid(cap_valid),
    .in_ready(cap_ready),
    .in_data(cap_word),
    .out_valid(head_valid),
    .out_ready(head_pop),
    .out_data(head_word)
  );

  // Storage never stalls; a full FIFO drops the sample and counts it
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      overflow_count <= '0;
    end else if (ce && cap_valid && !cap_ready &&
                 overflow_count != 8'hFF) begin
      overflow_count <= overflow_count + 8'h01;
    end
  end

  // ------------------------------------------------------------------
  // AXI4-Lite write channel
  // ------------------------------------------------------------------
  logic aw_held;
  logic w_held;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic do_write;

  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready = !w_held && !s_axi_bvalid;
  assign do_write = aw_held && w_held && !s_axi_bvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= '0;
      w_data <= '0;
      w_strb <= '0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else if (ce) begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (do_write) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid <= 1'b1;
        // Only control is writable; other offsets answer SLVERR
        s_axi_bresp <= is_ctrl_addr(aw_addr) ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl <= CTRL_RESET;
    end else if (ce && do_write && is_ctrl_addr(aw_addr)) begin
      ctrl <= apply_strobes(ctrl, w_data, w_strb) & 32'h0000_0F0F;
    end
  end

  // ------------------------------------------------------------------
  // AXI4-Lite read channel
  // ------------------------------------------------------------------
  logic [31:0] rd_value;
  logic rd_ok;

  assign s_axi_arready = !s_axi_rvalid;
  // Pop rides the accept, so rdata holds the popped word
  assign head_pop = ce && s_axi_arvalid && s_axi_arready &&
    s_axi_araddr[7:2] == FIFO_OFFSET[7:2] && head_valid;

  always_comb begin
    rd_value = '0;
    rd_ok = 1'b1;
    unique case (s_axi_araddr[7:2])
      CTRL_OFFSET[7:2]: rd_value = ctrl;
      STORE_OFFSET[7:2]: rd_value = {b_storage_register, a_storage_register};
      STATUS_OFFSET[7:2]: rd_value = {16'h0000, overflow_count,
        2'b00, cab_prev, cba_prev, !cap_ready, head_valid};
      FIFO_OFFSET[7:2]: rd_value = head_valid ? head_word : 32'h0000_0000;
      default: rd_ok = 1'b0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= RESP_OKAY;
    end else if (ce) begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_value;
        s_axi_rresp <= rd_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
endmodule : registered_bus_transceiver

// ==== design/sync_fifo.sv ====
// Purpose: Small synchronous FIFO with valid/ready on both sides
// Assumes: Depth is a power of two
// Notes: Full and empty come from an occupancy count
`timescale 1ns/1ps
module sync_fifo #(
  parameter int unsigned WIDTH = 32,
  parameter int unsigned DEPTH = 4
) (
  input wire logic aclk, // Clock
  input wire logic aresetn, // Sync reset, active low
  input wire logic ce, // Clock enable
  input wire logic in_valid, // Write request
  output logic in_ready, // Not full
  input wire logic [WIDTH-1:0] in_data, // Write word
  output logic out_valid, // Not empty
  input wire logic out_ready, // Read accept
  output logic [WIDTH-1:0] out_data // Head word
);
  localparam int unsigned AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] count;
  logic push;
  logic pop;

  assign in_ready = (count != (AW+1)'(DEPTH));
  assign out_valid = (count != '0);
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_data = mem[rd_ptr];

  always_ff @(posedge aclk) begin
    if (ce && push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else if (ce) begin
      if (push) begin
        wr_ptr <= wr_ptr + AW'(1);
      end
      if (pop) begin
        rd_ptr <= rd_ptr + AW'(1);
      end
      count <= count + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule : sync_fifo

// ==== inc/xcvr_pkg.sv ====
// Purpose: Shared constants and carriers for the registered bus transceiver
// Assumes: AXI4-Lite control, 32-bit data, byte-split 16-bit port path
// Notes: Offsets are byte addresses of aligned words
package xcvr_pkg;
  localparam int unsigned HALF_WIDTH = 8;
  localparam int unsigned NUM_HALVES = 2;
  localparam int unsigned PORT_WIDTH = 16;
  localparam int unsigned FIFO_DEPTH = 4;
  // ------------------------------------------------------------------
  // Register map
  // ------------------------------------------------------------------
  localparam logic [7:0] CTRL_OFFSET = 8'h00;
  localparam logic [7:0] STORE_OFFSET = 8'h04;
  localparam logic [7:0] STATUS_OFFSET = 8'h08;
  localparam logic [7:0] FIFO_OFFSET = 8'h0C;
  // Control field positions, per half: base + 8*half
  localparam int unsigned GATE_BIT = 0;
  localparam int unsigned FLOW_BIT = 1;
  localparam int unsigned BSEL_BIT = 2;
  localparam int unsigned ASEL_BIT = 3;
  localparam int unsigned CTRL_STRIDE = 8;
  // Output gate high after reset: both ports isolated
  localparam logic [31:0] CTRL_RESET = 32'h0000_0101;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef struct packed {
    logic output_gate;
    logic flow_sense;
    logic b_side_source_select;
    logic a_side_source_select;
  } half_ctrl_s;

  typedef struct packed {
    logic [PORT_WIDTH-1:0] a_level;
    logic [PORT_WIDTH-1:0] b_level;
  } capture_word_s;
endpackage : xcvr_pkg

// ==== sim/bus_agents.sv ====
// Purpose: Bus agents standing on ports A and B
// Assumes: Agents always drive; device enable wins per bit
// Notes: Released bits show the agent's own value
`timescale 1ns/1ps
module bus_agents #(
  parameter int unsigned W = 16
) (
  input wire logic [W-1:0] a_level, // Agent A value
  input wire logic [W-1:0] b_level, // Agent B value
  input wire logic [W-1:0] port_a_out, // Device A drive
  input wire logic [W-1:0] port_a_oe, // Device A enable
  input wire logic [W-1:0] port_b_out, // Device B drive
  input wire logic [W-1:0] port_b_oe, // Device B enable
  output logic [W-1:0] port_a_in, // Resolved A wire
  output logic [W-1:0] port_b_in // Resolved B wire
);
  // -------------------------------------------------------------
  // Wire resolution
  // -------------------------------------------------------------
  // Agent yields each bit the device drives
  assign port_a_in = (port_a_oe & port_a_out) | (~port_a_oe & a_level);
  assign port_b_in = (port_b_oe & port_b_out) | (~port_b_oe & b_level);
endmodule : bus_agents

// ==== sim/registered_bus_transceiver_tb.sv ====
// Purpose: Register-level tests of the registered transceiver
// Assumes: AXI4-Lite master changes signals after rising edges
// Notes: FIFO holds four capture words
`timescale 1ns/1ps
module registered_bus_transceiver_tb;
  import xcvr_pkg::*;
  logic aclk = 1'b0, aresetn = 1'b0, ce = 1'b1;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0000_0000, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'h0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [15:0] port_a_in, port_a_out, port_a_oe;
  logic [15:0] port_b_in, port_b_out, port_b_oe;
  logic [15:0] a_level = 16'h0000, b_level = 16'h0000;
  logic [1:0] a_to_b_capture_clock = 2'h0, b_to_a_capture_clock = 2'h0;
  int err_count = 0, checks_done = 0, cyc = 0;
  always #12.5 aclk = ~aclk;
  registered_bus_transceiver i_registered_bus_transceiver (
    .aclk, .aresetn, .ce, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .port_a_in, .port_a_out, .port_a_oe,
    .port_b_in, .port_b_out, .port_b_oe, .a_to_b_capture_clock,
    .b_to_a_capture_clock);
  bus_agents i_bus_agents (.a_level, .b_level, .port_a_out, .port_a_oe,
    .port_b_out, .port_b_oe, .port_a_in, .port_b_in);
  // -------------------------------------------------------------
  // Tasks
  // -------------------------------------------------------------
  task automatic results();
    $display("checks %0d errors %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : results
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : cmp
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] r);
    logic ta, tw, tk;
    logic [1:0] rs;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'hf;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    tk = 1'b0;
    while (!tk) begin
      @(negedge aclk);
      ta = s_axi_awvalid & s_axi_awready;
      tw = s_axi_wvalid & s_axi_wready;
      tk = s_axi_bvalid;
      rs = s_axi_bresp;
      @(posedge aclk);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
    end
    s_axi_bready <= 1'b0;
    cmp({30'h0, rs}, {30'h0, r});
  endtask : wr
  task automatic rdc(input logic [7:0] a, input logic [31:0] e,
                     input logic [1:0] r);
    logic ta, tk;
    logic [31:0] d;
    logic [1:0] rs;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    tk = 1'b0;
    while (!tk) begin
      @(negedge aclk);
      ta = s_axi_arvalid & s_axi_arready;
      tk = s_axi_rvalid;
      d = s_axi_rdata;
      rs = s_axi_rresp;
      @(posedge aclk);
      if (ta) s_axi_arvalid <= 1'b0;
    end
    // rready stays high; each call sets it again and no call clears it
    cmp(d, e);
    cmp({30'h0, rs}, {30'h0, r});
  endtask : rdc
  task automatic pchk(input logic [31:0] e);
    @(negedge aclk);
    cmp({port_a_in, port_b_in}, e);
    @(posedge aclk);
  endtask : pchk
  task automatic ctl(input logic [31:0] v, input logic [15:0] ea,
                     input logic [15:0] eb);
    wr(CTRL_OFFSET, v, RESP_OKAY);
    rdc(CTRL_OFFSET, v, RESP_OKAY);
    @(negedge aclk);
    cmp({port_a_oe, port_b_oe}, {ea, eb});
    @(posedge aclk);
  endtask : ctl
  task automatic pulse(input logic [1:0] ab, input logic [1:0] ba);
    @(posedge aclk);
    a_to_b_capture_clock <= ab;
    b_to_a_capture_clock <= ba;
    @(posedge aclk);
    a_to_b_capture_clock <= 2'h0;
    b_to_a_capture_clock <= 2'h0;
    // Levels move right after capture so stored and live differ
    a_level <= ~a_level;
    b_level <= ~b_level;
    @(posedge aclk);
    a_level <= ~a_level;
    b_level <= ~b_level;
    @(posedge aclk);
  endtask : pulse
  // Whole run is about 130 cycles
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 4000) begin
      err_count++;
      $display("[ERR] %0t run did not finish", $time);
      results();
    end
  end
  initial begin
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    @(negedge aclk);
    cmp({port_a_oe, port_b_oe}, 32'h0000_0000);
    @(posedge aclk);
    rdc(CTRL_OFFSET, CTRL_RESET, RESP_OKAY);
    rdc(8'h10, 32'h0000_0000, RESP_SLVERR);
    a_level <= 16'h1234;
    b_level <= 16'habcd;
    for (int h = 0; h < 2; h++) begin
      pulse(2'(1 << h), 2'h0);
      pulse(2'h0, 2'(1 << h));
    end
    rdc(STORE_OFFSET, 32'habcd_1234, RESP_OKAY);
    for (int i = 0; i < 4; i++)
      rdc(FIFO_OFFSET, 32'h1234_abcd, RESP_OKAY);
    a_level <= 16'h5a5a;
    b_level <= 16'hc3c3;
    wr(STORE_OFFSET, 32'hffff_ffff, RESP_SLVERR);
    rdc(STORE_OFFSET, 32'habcd_1234, RESP_OKAY);
    ctl(32'h0000_0102, 16'h0000, 16'h00ff);
    pchk(32'h5a5a_c35a);
    ctl(32'h0000_0106, 16'h0000, 16'h00ff);
    pchk(32'h5a5a_c334);
    a_level <= 16'h7e7e;
    pulse(2'h1, 2'h0);
    pchk(32'h7e7e_c37e);
    ctl(32'h0000_0801, 16'hff00, 16'h0000);
    pchk(32'hab7e_c3c3);
    b_level <= 16'h9696;
    pulse(2'h0, 2'h2);
    pchk(32'h967e_9696);
    b_level <= 16'h4b4b;
    ctl(32'h0000_0001, 16'hff00, 16'h0000);
    pchk(32'h4b7e_4b4b);
    rdc(FIFO_OFFSET, 32'h7e7e_c334, RESP_OKAY);
    rdc(FIFO_OFFSET, 32'hab7e_9696, RESP_OKAY);
    ctl(CTRL_RESET, 16'h0000, 16'h0000);
    for (int i = 0; i < 5; i++) begin
      a_level <= 16'h1000 + 16'(i);
      pulse(2'h1, 2'h0);
    end
    rdc(STATUS_OFFSET, 32'h0000_0103, RESP_OKAY);
    for (int i = 0; i < 4; i++)
      rdc(FIFO_OFFSET, {16'h1000 + 16'(i), 16'h4b4b}, RESP_OKAY);
    rdc(FIFO_OFFSET, 32'h0000_0000, RESP_OKAY);
    rdc(STATUS_OFFSET, 32'h0000_0100, RESP_OKAY);
    // Clock enable low: capture rises must be ignored
    a_level <= 16'h2222;
    b_level <= 16'h3333;
    ce <= 1'b0;
    pulse(2'h3, 2'h3);
    ce <= 1'b1;
    rdc(STORE_OFFSET, 32'h96cd_1204, RESP_OKAY);
    results();
  end
endmodule : registered_bus_transceiver_tb

// ==== sim/xcvr_chk.sv ====
// Purpose: Port-level checks for the registered transceiver
// Assumes: Capture clocks are levels sampled on aclk
// Notes: Shadow storage mirrors each capture rise
`timescale 1ns/1ps
module xcvr_chk #(
  parameter int unsigned HALF_W = 8
) (
  input wire logic aclk, // Clock
  input wire logic aresetn, // Sync reset, active low
  input wire logic ce, // Clock enable
  input wire logic s_axi_bvalid, // Write response valid
  input wire logic [2*HALF_W-1:0] port_a_in, // Port A level
  input wire logic [2*HALF_W-1:0] port_a_out, // Port A drive value
  input wire logic [2*HALF_W-1:0] port_a_oe, // Port A enable
  input wire logic [2*HALF_W-1:0] port_b_in, // Port B level
  input wire logic [2*HALF_W-1:0] port_b_out, // Port B drive value
  input wire logic [2*HALF_W-1:0] port_b_oe, // Port B enable
  input wire logic [1:0] a_to_b_capture_clock, // A capture clocks
  input wire logic [1:0] b_to_a_capture_clock // B capture clocks
);
  localparam int unsigned H = HALF_W;
  logic [2*HALF_W-1:0] sa, sb;
  logic [1:0] pab, pba;
  // -------------------------------------------------------------
  // Shadow storage
  // -------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pab <= 2'h3;
      pba <= 2'h3;
    end else if (ce) begin
      pab <= a_to_b_capture_clock;
      pba <= b_to_a_capture_clock;
    end
  end
  // No reset here, like the real storage
  always_ff @(posedge aclk) begin
    for (int h = 0; h < 2; h++) begin
      if (aresetn && ce && a_to_b_capture_clock[h] && !pab[h])
        sa[h*H +: H] <= port_a_in[h*H +: H];
      if (aresetn && ce && b_to_a_capture_clock[h] && !pba[h])
        sb[h*H +: H] <= port_b_in[h*H +: H];
    end
  end
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence rise_ab0;
    ce && a_to_b_capture_clock[0] && !pab[0];
  endsequence
  sequence rise_ba1;
    ce && b_to_a_capture_clock[1] && !pba[1];
  endsequence
  dual_drive_a: assert property ((port_a_oe & port_b_oe) == '0)
    else $error("both ports driven");
  half_oe_a: assert property (
    (&port_a_oe[H-1:0]) == (|port_a_oe[H-1:0]) &&
    (&port_a_oe[2*H-1:H]) == (|port_a_oe[2*H-1:H]) &&
    (&port_b_oe[H-1:0]) == (|port_b_oe[H-1:0]) &&
    (&port_b_oe[2*H-1:H]) == (|port_b_oe[2*H-1:H]))
    else $error("enable split inside a half");
  reset_iso_a: assert property (disable iff (1'b0)
    !aresetn |=> (port_a_oe | port_b_oe) == '0)
    else $error("port driven after reset");
  b_source_a: assert property (
    ((port_b_out ^ port_a_in) & (port_b_out ^ sa) & port_b_oe) == '0)
    else $error("port B neither live nor stored");
  a_source_a: assert property (
    ((port_a_out ^ port_b_in) & (port_a_out ^ sb) & port_a_oe) == '0)
    else $error("port A neither live nor stored");
  stored_b_a: assert property (rise_ab0 ##1 (port_b_oe[0] &&
    port_b_out[H-1:0] != port_a_in[H-1:0]) |->
    port_b_out[H-1:0] == $past(port_a_in[H-1:0]))
    else $error("port B misses new capture");
  stored_a_a: assert property (rise_ba1 ##1 (port_a_oe[H] &&
    port_a_out[2*H-1:H] != port_b_in[2*H-1:H]) |->
    port_a_out[2*H-1:H] == $past(port_b_in[2*H-1:H]))
    else $error("port A misses new capture");
  oe_change_a: assert property (
    $changed({port_a_oe, port_b_oe}) |-> $rose(s_axi_bvalid))
    else $error("direction changed without a write");
endmodule : xcvr_chk

bind registered_bus_transceiver xcvr_chk #(.HALF_W(HALF_W)) i_xcvr_chk (
  .aclk, .aresetn, .ce, .s_axi_bvalid, .port_a_in, .port_a_out,
  .port_a_oe, .port_b_in, .port_b_out, .port_b_oe,
  .a_to_b_capture_clock, .b_to_a_capture_clock);
